/* shared/srlu_pkg.sv */
// Register map, field positions and shared types of the set-reset latch unit
`default_nettype none
package srlu_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] SRCEN_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;
  // Control register fields
  localparam int LEN_BIT = 7;
  localparam int DIV_LSB = 4;
  localparam int DIV_W = 3;
  localparam int QEN_BIT = 3;
  localparam int NQEN_BIT = 2;
  localparam int SPS_BIT = 1;
  localparam int SPR_BIT = 0;
  // Source enable register fields
  localparam int PSE_BIT = 7;
  localparam int CSE_BIT = 6;
  localparam int C2SE_BIT = 5;
  localparam int C1SE_BIT = 4;
  localparam int PRE_BIT = 3;
  localparam int CRE_BIT = 2;
  localparam int C2RE_BIT = 1;
  localparam int C1RE_BIT = 0;
  // Reset values and divider geometry
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SRCEN_RST = 8'h00;
  localparam int DIV_MIN_LOG2 = 2;
  localparam int CNT_W = 9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Asynchronous source bundle
  typedef struct packed {
    logic comp_two;
    logic comp_one;
    logic irq_pin;
  } srlu_src_t;
  // Pin outputs bundle
  typedef struct packed {
    logic q;
    logic q_oe;
    logic nq;
    logic nq_oe;
  } srlu_pins_t;
endpackage
`default_nettype wire

/* src/srlu_top.sv */
// Set-reset latch unit with AXI4-Lite registers
// What this block does
// - Every set and reset input is active high; comparators, pin, divided clock, software.
// - Any active reset together with any active set leaves the latch reset; pin, comparator and clock sources act only while the latch enable bit is set.
// - Writing one to soft set or soft reset pulses the latch; bits read zero.
// - Divider codes 000 to 111 give periods 4 through 512 cycles.
// - True output enable bit drives the latch output onto its pin.
// - Inverted output enable bit drives the complement onto its pin.
// - Device reset does not initialise the latch state.
// - Pin set enable lets a high interrupt pin set the latch.
// - Clock set enable lets the divided clock pulse set the latch.
// - Comparator two and one set enables each let that comparator set.
// - Pin reset enable lets a high interrupt pin reset the latch.
// - Clock reset enable lets the divided clock pulse reset the latch.
// - Comparator two and one reset enables each let that comparator reset.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
module srlu_top #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Asynchronous latch sources
  input wire srlu_pkg::srlu_src_t src_in,
  // Latch outputs and pin drives
  output srlu_pkg::srlu_pins_t pins_out
);
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("SYNC_STAGES must be at least 2");
    end
  end

  logic [7:0] ctrl_ff;
  logic [7:0] srcen_ff;
  logic soft_set_ff;
  logic soft_rst_ff;
  logic latch_ff;
  logic [srlu_pkg::CNT_W-1:0] cnt_ff;
  logic tick_ff;
  logic [2:0] sync_ff [SYNC_STAGES];
  srlu_pkg::srlu_pins_t pins_ff;
  // AXI state
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Address decode, shared by read and write
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == srlu_pkg::CTRL_ADDR) || (a == srlu_pkg::SRCEN_ADDR) || (a == srlu_pkg::STATUS_ADDR);
  endfunction

  // Write channel: take address and data in either order, answer after both
  wire aw_take = s_axi_awvalid && !aw_hold_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_hold_ff && !bvalid_ff;
  wire have_aw = aw_hold_ff || aw_take;
  wire have_w = w_hold_ff || w_take;
  wire wr_fire = have_aw && have_w && !bvalid_ff;
  wire [3:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_ctrl = wr_lane0 && (wr_addr == srlu_pkg::CTRL_ADDR);
  wire wr_srcen = wr_lane0 && (wr_addr == srlu_pkg::SRCEN_ADDR);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= srlu_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= have_aw && !wr_fire;
      w_hold_ff <= have_w && !wr_fire;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_ok(wr_addr) ? srlu_pkg::RESP_OKAY : srlu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Payload capture needs no reset
  always_ff @(posedge clk_sys) begin
    if (aw_take) begin
      awaddr_ff <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  // Register writes; pulse bits never stored so they read back zero
  wire [7:0] nxt_ctrl = wr_ctrl ? {wr_data[7:2], 2'b00} : ctrl_ff;
  wire latch_en = ctrl_ff[srlu_pkg::LEN_BIT];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= srlu_pkg::CTRL_RST;
      srcen_ff <= srlu_pkg::SRCEN_RST;
      soft_set_ff <= 1'b0;
      soft_rst_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_srcen) begin
        srcen_ff <= wr_data[7:0];
      end
      soft_set_ff <= wr_ctrl && wr_data[srlu_pkg::SPS_BIT];
      soft_rst_ff <= wr_ctrl && wr_data[srlu_pkg::SPR_BIT];
    end
  end

  // Read channel: one cycle from address to data
  wire rd_take = s_axi_arvalid && !rvalid_ff;
  wire [31:0] status_word = {30'h0, ~latch_ff, latch_ff};
  wire [31:0] rd_word = (s_axi_araddr == srlu_pkg::CTRL_ADDR) ? {24'h0, ctrl_ff} :
                        (s_axi_araddr == srlu_pkg::SRCEN_ADDR) ? {24'h0, srcen_ff} :
                        (s_axi_araddr == srlu_pkg::STATUS_ADDR) ? status_word : 32'h0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= srlu_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= addr_ok(s_axi_araddr) ? srlu_pkg::RESP_OKAY : srlu_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Source synchronisers; only the last stage is used downstream
  always_ff @(posedge clk_sys) begin
    sync_ff[0] <= src_in;
  end
  for (genvar i = 1; i < SYNC_STAGES; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      sync_ff[i] <= sync_ff[i-1];
    end
  end
  wire [2:0] src_s = sync_ff[SYNC_STAGES-1];
  wire irq_s = src_s[0];
  wire c1_s = src_s[1];
  wire c2_s = src_s[2];

  // Divider: terminal count 2^(code+2)-1; held clear while disabled
  wire [2:0] div_code = ctrl_ff[srlu_pkg::DIV_LSB +: srlu_pkg::DIV_W];
  // Shift amount kept four bits wide so codes 6 and 7 do not wrap to small periods
  wire [3:0] div_shift = {1'b0, div_code} + 4'(srlu_pkg::DIV_MIN_LOG2);
  wire [srlu_pkg::CNT_W-1:0] div_last =
    srlu_pkg::CNT_W'((10'h1 << div_shift) - 10'h1);
  wire div_wrap = (cnt_ff >= div_last);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !latch_en) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= div_wrap ? '0 : cnt_ff + 1'b1;
      tick_ff <= div_wrap;
    end
  end

  // Set and reset terms, all active high
  wire set_any = (srcen_ff[srlu_pkg::PSE_BIT] && irq_s)
               | (srcen_ff[srlu_pkg::CSE_BIT] && tick_ff)
               | (srcen_ff[srlu_pkg::C2SE_BIT] && c2_s)
               | (srcen_ff[srlu_pkg::C1SE_BIT] && c1_s)
               | soft_set_ff;
  wire rst_any = (srcen_ff[srlu_pkg::PRE_BIT] && irq_s)
               | (srcen_ff[srlu_pkg::CRE_BIT] && tick_ff)
               | (srcen_ff[srlu_pkg::C2RE_BIT] && c2_s)
               | (srcen_ff[srlu_pkg::C1RE_BIT] && c1_s)
               | soft_rst_ff;
  // Reset dominates; software pulses act even while disabled so firmware can preset
  wire hw_ok = latch_en;
  wire do_rst = soft_rst_ff || (hw_ok && rst_any);
  wire do_set = soft_set_ff || (hw_ok && set_any);
  wire nxt_latch = do_rst ? 1'b0 : (do_set ? 1'b1 : latch_ff);

  // Latch state deliberately outside the reset
  always_ff @(posedge clk_sys) begin
    latch_ff <= nxt_latch;
  end

  // Pin drives registered and cleared by reset; pin value otherwise follows the latch, output enables are separate outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pins_ff <= '0;
    end else begin
      pins_ff.q <= nxt_latch;
      pins_ff.nq <= ~nxt_latch;
      pins_ff.q_oe <= nxt_ctrl[srlu_pkg::QEN_BIT];
      pins_ff.nq_oe <= nxt_ctrl[srlu_pkg::NQEN_BIT];
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pins_out = pins_ff;
endmodule
`default_nettype wire

/* verif/srlu_checker.sv */
// Bus and latch timing checks for the set-reset latch unit
`default_nettype none
module srlu_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Latch pins
  input wire srlu_pkg::srlu_pins_t pins_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Both write channels taken in one cycle
  wire wboth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Control write that reaches the low byte
  wire wctl = wboth && s_axi_awaddr == srlu_pkg::CTRL_ADDR && s_axi_wstrb[0];
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  a_write_answer: assert property (wboth |=> s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
    |=> s_axi_rresp == srlu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_soft_set: assert property (wctl && s_axi_wdata[1:0] == 2'h2 |-> ##3 pins_out.q) else $error("no soft set");
  a_soft_reset: assert property (wctl && s_axi_wdata[0] |-> ##3 !pins_out.q) else $error("no soft reset");
  a_pin_enables: assert property (wctl |-> ##3 pins_out.q_oe == $past(s_axi_wdata[3], 3)
    && pins_out.nq_oe == $past(s_axi_wdata[2], 3)) else $error("pin enable wrong");
  a_complement: assert property (!$past(sys_rst) && $changed(pins_out.q) |-> pins_out.nq == !pins_out.q)
    else $error("complement wrong");
endmodule
bind srlu_top srlu_checker u_chk (.*);
`default_nettype wire

/* verif/srlu_top_bench.sv */
// Register-level tests of the set-reset latch unit
`default_nettype none
module srlu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] A_CTL = srlu_pkg::CTRL_ADDR;
  localparam logic [3:0] A_SRC = srlu_pkg::SRCEN_ADDR;
  localparam logic [3:0] A_STA = srlu_pkg::STATUS_ADDR;
  logic clk_sys;
  logic sys_rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  srlu_pkg::srlu_src_t src_in = 3'h0;
  srlu_pkg::srlu_pins_t pins_out;
  // Source that each enable bit pair listens to, by bit position modulo four
  srlu_pkg::srlu_src_t sel [4] = '{3'h2, 3'h4, 3'h0, 3'h1};
  int errors = 0;
  int checks = 0;
  srlu_top u_dut (.*);
  // Free-running system clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Leading edge keeps two tasks from driving one strobe in the same step
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 99);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 99);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is well under this span
  initial begin
    #300us;
    errors++;
    end_of_test();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n, n0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(A_CTL, d, r);
    chk(d, {24'h0, srlu_pkg::CTRL_RST});
    rd(4'hC, d, r);
    chk({r, d[29:0]}, {srlu_pkg::RESP_SLVERR, 30'h0});
    wr(A_CTL, 8'hFF, 4'h0);
    wr(A_SRC, 8'hA5, 4'hF);
    rd(A_CTL, d, r);
    chk(d, 32'h0);
    rd(A_SRC, d, r);
    chk(d, 32'hA5);
    $display("registers done");
    wr(A_CTL, 8'h02, 4'hF);
    wr(A_SRC, 8'h00, 4'hF);
    rd(A_STA, d, r);
    chk(d, 32'h1);
    rd(A_CTL, d, r);
    chk(d, 32'h0);
    wr(A_CTL, 8'h01, 4'hF);
    rd(A_STA, d, r);
    chk(d, 32'h2);
    wr(A_CTL, 8'h8C, 4'hF);
    rd(A_CTL, d, r);
    chk(d, 32'h8C);
    chk({28'h0, pins_out}, 32'h7);
    $display("soft pulses and pins done");
    // Each enable alone with its source high
    for (int i = 0; i < 8; i++) begin
      wr(A_CTL, i > 3 ? 8'h81 : 8'h82, 4'hF);
      wr(A_SRC, 8'h01 << i, 4'hF);
      src_in <= sel[i % 4];
      repeat (12) @(posedge clk_sys);
      chk({31'h0, pins_out.q}, {31'h0, i > 3});
      src_in <= 3'h0;
      wr(A_SRC, 8'h00, 4'hF);
    end
    src_in <= 3'h7;
    repeat (12) @(posedge clk_sys);
    chk({31'h0, pins_out.q}, 32'h1);
    wr(A_CTL, 8'h82, 4'hF);
    wr(A_SRC, 8'h88, 4'hF);
    src_in <= 3'h1;
    repeat (12) @(posedge clk_sys);
    chk({31'h0, pins_out.q}, 32'h0);
    src_in <= 3'h0;
    $display("sources done");
    wr(A_SRC, 8'h40, 4'hF);
    for (int c = 0; c < 8; c++) begin
      wr(A_CTL, 8'h01, 4'hF);
      wr(A_CTL, 8'(8'h80 | (c << 4)), 4'hF);
      n = 0;
      while (pins_out.q !== 1'h1 && n < 2000) begin
        @(posedge clk_sys);
        n++;
      end
      if (c == 0) n0 = n;
      chk(32'(n - n0), 32'(4 << c) - 32'h4);
    end
    $display("divider done");
    wr(A_CTL, 8'h02, 4'hF);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(A_STA, d, r);
    chk(d, 32'h1);
    $display("reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
